// [tb.sv]
// Purpose: self-checking bench for wrf_top
// Assumes: short oscillator divider
// Notes: seed 8
`timescale 1ns/1ps
module tb;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, watchdog_irq;
	logic external_reset_req, brownout_reset_req, watchdog_always_on_fuse;
	logic global_irq_enable, watchdog_restart, watchdog_vector_taken;
	logic watchdog_system_reset;
	logic [9:0] awaddr, araddr, ra;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	int error_cnt, n_tests, n;
	localparam int unsigned div = 4;
	localparam logic [9:0] a_pr = {wrf_pkg::protect_idx, 2'b00};
	localparam logic [9:0] a_rc = {wrf_pkg::reset_cause_idx, 2'b00};
	localparam logic [9:0] a_ct = {wrf_pkg::ctrl_idx, 2'b00};
	wrf_top #(.osc_div(div)) dut_u (.aclk, .aresetn, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.external_reset_req, .brownout_reset_req, .watchdog_always_on_fuse,
		.global_irq_enable, .watchdog_restart, .watchdog_vector_taken,
		.watchdog_irq, .watchdog_system_reset);
	initial
	begin
		aclk = 0;
		forever #4 aclk = ~aclk;
	end
	function automatic int exp_to(input int p);
		return (512 << p) * div;
	endfunction
	task automatic tally_and_finish();
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic tmo();
		error_cnt++;
		tally_and_finish();
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] v);
		int i;
		logic ha, hw, hb;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h00_0000, v};
		{awvalid, wvalid, bready} <= 3'h7;
		for (i = 0; i < 200; i++)
		begin
			@(negedge aclk);
			ha = awvalid && awready;
			hw = wvalid && wready;
			hb = bvalid;
			rs = bresp;
			@(posedge aclk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (hb) break;
		end
		bready <= 1'b0;
		if (i == 200) tmo();
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		int i;
		logic ha, hr;
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		for (i = 0; i < 200; i++)
		begin
			@(negedge aclk);
			ha = arvalid && arready;
			hr = rvalid;
			d = rdata;
			rs = rresp;
			@(posedge aclk);
			if (ha) arvalid <= 1'b0;
			if (hr) break;
		end
		rready <= 1'b0;
		if (i == 200) tmo();
		chk(d, {24'h00_0000, e});
	endtask
	task automatic wait_ev(input bit s);
		for (n = 0; n < 20000; n++)
		begin
			@(negedge aclk);
			if ((s ? watchdog_system_reset : watchdog_irq) === 1'b1) break;
		end
		if (n == 20000) tmo();
	endtask
	task automatic chip_rst(input bit b);
		@(posedge aclk);
		external_reset_req <= !b;
		brownout_reset_req <= b;
		repeat (3 + $urandom % 5) @(posedge aclk);
		{external_reset_req, brownout_reset_req} <= 2'h0;
		repeat (8) @(posedge aclk);
	endtask
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = {52'h0, 4'hf};
		{external_reset_req, brownout_reset_req} = '0;
		{watchdog_always_on_fuse, global_irq_enable} = '0;
		{watchdog_restart, watchdog_vector_taken} = '0;
		{error_cnt, n_tests} = '0;
		void'($urandom(8));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(a_rc, 8'h01);
		rd(a_ct, 8'h00);
		wr(a_rc, 8'h00);
		rd(a_rc, 8'h00);
		ra = {2'b01, 6'($urandom), 2'b00};
		rd(ra, 8'h00);
		chk(32'(rs), 32'(wrf_pkg::resp_slverr));
		wr(ra, 8'hff);
		chk(32'(rs), 32'(wrf_pkg::resp_slverr));
		chip_rst(0);
		rd(a_rc, 8'h02);
		chip_rst(1);
		rd(a_rc, 8'h06);
		wr(a_rc, 8'h00);
		global_irq_enable <= 1'b1;
		wr(a_ct, 8'h40);
		watchdog_restart <= 1'b1;
		@(posedge aclk);
		watchdog_restart <= 1'b0;
		wait_ev(0);
		chk(32'(n > exp_to(0) - 9 && n < exp_to(0) + 9), 1);
		wr(a_ct, 8'h40);
		rd(a_ct, 8'hc0);
		global_irq_enable <= 1'b0;
		@(negedge aclk);
		chk(32'(watchdog_irq), 0);
		global_irq_enable <= 1'b1;
		wr(a_ct, 8'hc0);
		rd(a_ct, 8'h40);
		wait_ev(0);
		watchdog_vector_taken <= 1'b1;
		@(posedge aclk);
		watchdog_vector_taken <= 1'b0;
		@(negedge aclk);
		chk(32'(watchdog_irq), 0);
		wr(a_ct, 8'h48);
		watchdog_restart <= 1'b1;
		@(posedge aclk);
		watchdog_restart <= 1'b0;
		repeat (exp_to(0) + 8) @(posedge aclk);
		rd(a_ct, 8'h88);
		wait_ev(1);
		repeat (4) @(posedge aclk);
		rd(a_rc, 8'h08);
		rd(a_ct, 8'h08);
		wr(a_ct, 8'h00);
		rd(a_ct, 8'h08);
		wr(a_rc, 8'h00);
		wr(a_ct, 8'h0b);
		rd(a_ct, 8'h08);
		wr(a_pr, wrf_pkg::protect_signature);
		wr(a_ct, 8'h21);
		rd(a_ct, 8'h21);
		watchdog_always_on_fuse <= 1'b1;
		repeat (4) @(posedge aclk);
		rd(a_ct, 8'h29);
		wr(a_pr, wrf_pkg::protect_signature);
		wr(a_ct, 8'h20);
		rd(a_ct, 8'h28);
		tally_and_finish();
	end
endmodule

// [wrf_axil.sv]
// Purpose: AXI4-Lite slave front end for the watchdog registers
// Assumes: one write and one read outstanding at most
// Notes: only byte lane 0 carries data; unmapped gives SLVERR
`timescale 1ns/1ps
module wrf_axil
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write address and data
	input wire logic [wrf_pkg::addr_w-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read
	input wire logic [wrf_pkg::addr_w-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// register side
	output wrf_pkg::wrf_wr_t wr,
	output logic [wrf_pkg::idx_w-1:0] rd_idx,
	input wire logic [7:0] rd_data
);
	typedef struct packed {
		logic aw_full;
		logic [wrf_pkg::idx_w-1:0] aw_idx;
		logic w_full;
		logic [7:0] w_data;
		logic w_lane;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		wrf_pkg::wrf_wr_t wr;
	} wrf_axil_st_t;

	wrf_axil_st_t st_r;
	wrf_axil_st_t st_nxt;

	assign awready = !st_r.aw_full;
	assign wready = !st_r.w_full;
	assign arready = !st_r.rvalid;
	assign bvalid = st_r.bvalid;
	assign bresp = st_r.bresp;
	assign rvalid = st_r.rvalid;
	assign rresp = st_r.rresp;
	assign rdata = {24'h00_0000, st_r.rdata};
	assign wr = st_r.wr;
	assign rd_idx = araddr[wrf_pkg::addr_w-1:2];

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.wr.en = 1'b0;
		if (awvalid && !st_r.aw_full)
		begin
			st_nxt.aw_full = 1'b1;
			st_nxt.aw_idx = awaddr[wrf_pkg::addr_w-1:2];
		end
		if (wvalid && !st_r.w_full)
		begin
			st_nxt.w_full = 1'b1;
			st_nxt.w_data = wdata[7:0];
			st_nxt.w_lane = wstrb[0];
		end
		if (st_r.bvalid && bready)
			st_nxt.bvalid = 1'b0;
		if (st_r.aw_full && st_r.w_full && !st_r.bvalid)
		begin
			st_nxt.aw_full = 1'b0;
			st_nxt.w_full = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = wrf_pkg::idx_hit(st_r.aw_idx) ?
				wrf_pkg::resp_okay : wrf_pkg::resp_slverr;
			st_nxt.wr.en = st_r.w_lane && wrf_pkg::idx_hit(st_r.aw_idx);
			st_nxt.wr.idx = st_r.aw_idx;
			st_nxt.wr.data = st_r.w_data;
		end
		if (st_r.rvalid && rready)
			st_nxt.rvalid = 1'b0;
		if (arvalid && !st_r.rvalid)
		begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = rd_data;
			st_nxt.rresp = wrf_pkg::idx_hit(rd_idx) ?
				wrf_pkg::resp_okay : wrf_pkg::resp_slverr;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
endmodule

// [wrf_pkg.sv]
// Purpose: shared constants and types for the watchdog and reset flags
// Assumes: 125 MHz aclk, AXI4-Lite register access
// Notes: register index times four gives the byte address
package wrf_pkg;
	localparam int unsigned clk_period_ns = 8;
	localparam int unsigned osc_period_ns = 31250;
	localparam int unsigned osc_div_cycles = osc_period_ns / clk_period_ns;
	localparam int unsigned instr_cycle_ns = 64;
	localparam int unsigned protect_window_instr = 4;
	localparam int unsigned protect_window_cycles =
		protect_window_instr * instr_cycle_ns / clk_period_ns;
	localparam int unsigned div_w = 12;
	localparam int unsigned win_w = 6;
	localparam int unsigned cnt_w = 18;
	localparam int unsigned addr_w = 10;
	localparam int unsigned idx_w = 8;
	localparam logic [idx_w-1:0] protect_idx = 8'h34;
	localparam logic [idx_w-1:0] reset_cause_idx = 8'h35;
	localparam logic [idx_w-1:0] ctrl_idx = 8'h36;
	localparam int unsigned rc_wd_bit = 3;
	localparam int unsigned rc_bo_bit = 2;
	localparam int unsigned rc_ext_bit = 1;
	localparam int unsigned rc_po_bit = 0;
	localparam logic [3:0] rc_reset = 4'h1;
	localparam int unsigned ct_flag_bit = 7;
	localparam int unsigned ct_ien_bit = 6;
	localparam int unsigned ct_psel3_bit = 5;
	localparam int unsigned ct_en_bit = 3;
	localparam logic [7:0] protect_signature = 8'hd8;
	localparam logic [3:0] psel_max = 4'h9;
	localparam logic [cnt_w-1:0] timeout_base = 18'h0_0200;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

	typedef struct packed {
		logic en;
		logic [idx_w-1:0] idx;
		logic [7:0] data;
	} wrf_wr_t;

	function automatic logic idx_hit(input logic [idx_w-1:0] idx);
		idx_hit = (idx == protect_idx) || (idx == reset_cause_idx) ||
			(idx == ctrl_idx);
	endfunction
endpackage

// [wrf_properties.sv]
// Purpose: port checks for the watchdog block
// Assumes: one aclk domain, synchronous aresetn
// Notes: bound to wrf_top
`timescale 1ns/1ps
module wrf_chk
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	// watchdog
	input wire logic global_irq_enable,
	input wire logic watchdog_vector_taken,
	input wire logic watchdog_irq,
	input wire logic watchdog_system_reset
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_ar;
		arvalid && arready;
	endsequence
	sequence s_rw;
		rvalid && !rready;
	endsequence
	property p_irq_gate;
		watchdog_irq |-> global_irq_enable;
	endproperty
	property p_vec_clr;
		watchdog_vector_taken |=> !watchdog_irq;
	endproperty
	property p_rst_pulse;
		watchdog_system_reset |=> !watchdog_system_reset;
	endproperty
	property p_rst_irq;
		watchdog_system_reset |=> !watchdog_irq [*2];
	endproperty
	property p_rd_hi;
		rvalid |-> rdata[31:8] == 24'h00_0000;
	endproperty
	property p_rd_lat;
		s_ar |=> rvalid;
	endproperty
	property p_r_hold;
		s_rw |=> rvalid && $stable(rdata);
	endproperty
	property p_b_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	property p_ar_blk;
		rvalid |-> !arready;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("irq without enable");
	a_vec_clr: assert property (p_vec_clr)
		else $error("flag kept");
	a_rst_pulse: assert property (p_rst_pulse)
		else $error("reset too long");
	a_rst_irq: assert property (p_rst_irq)
		else $error("irq after reset");
	a_rd_hi: assert property (p_rd_hi)
		else $error("upper bits set");
	a_rd_lat: assert property (p_rd_lat)
		else $error("read late");
	a_r_hold: assert property (p_r_hold)
		else $error("read moved");
	a_b_hold: assert property (p_b_hold)
		else $error("resp moved");
	a_ar_blk: assert property (p_ar_blk)
		else $error("ar taken");
endmodule
bind wrf_top wrf_chk chk_u (.aclk, .aresetn, .bresp, .bvalid, .bready,
	.arvalid, .arready, .rdata, .rvalid, .rready, .global_irq_enable,
	.watchdog_vector_taken, .watchdog_irq, .watchdog_system_reset);

// [wrf_top.sv]
// Purpose: watchdog timer with reset cause flags behind AXI4-Lite
// Assumes: slow oscillator made from aclk by a divider enable
// Notes: aresetn is the power-on reset of the block
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Function
// - reset cause bits 7:4 read zero
// - watchdog reset sets its cause flag
// - brown-out reset sets its cause flag
// - external reset sets its cause flag
// - power-on sets flag; only software zero clears
// - interrupt mode timeout sets flag; vector clears
// - writing one clears interrupt flag
// - irq needs global, enable and flag set
// - enables select stopped, interrupt or reset
// - both enables: timeout clears interrupt enable
// - enable bit written one enables, zero disables only inside protected window
// - level two keeps watchdog always enabled
// - level one: reset flag forces enable
// - four-bit prescaler selects 512 to 256K
// - reserved prescaler codes fall back below
// - prescaler changes only inside protected window
// - signature opens the change window
// - count restarts on disable, reset, restart
// - level one starts disabled, level two enabled
module wrf_top
#(
	parameter int unsigned osc_div = wrf_pkg::osc_div_cycles
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write address channel
	input wire logic [wrf_pkg::addr_w-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// write data channel
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// write response channel
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read address channel
	input wire logic [wrf_pkg::addr_w-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// read data channel
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// reset sources and always-on fuse from pins
	input wire logic external_reset_req,
	input wire logic brownout_reset_req,
	input wire logic watchdog_always_on_fuse,
	// processor side
	input wire logic global_irq_enable,
	input wire logic watchdog_restart,
	input wire logic watchdog_vector_taken,
	// outputs
	output logic watchdog_irq,
	output logic watchdog_system_reset
);
	typedef struct packed {
		logic [1:0] ext_sync;
		logic [1:0] bod_sync;
		logic [1:0] fuse_sync;
		logic [3:0] rc;
		logic int_flag;
		logic int_en;
		logic wd_en;
		logic [3:0] psel;
		logic [wrf_pkg::div_w-1:0] div_cnt;
		logic [wrf_pkg::cnt_w-1:0] wd_cnt;
		logic [wrf_pkg::win_w-1:0] win_cnt;
		logic sys_rst;
	} wrf_st_t;

	wrf_st_t st_r;
	wrf_st_t st_nxt;
	wrf_pkg::wrf_wr_t wr;
	logic [wrf_pkg::idx_w-1:0] rd_idx;
	logic [7:0] rd_data;
	logic level2;
	logic en_eff;
	logic running;
	logic osc_tick;
	logic timeout;
	logic win_open;
	logic chip_rst;
	logic [3:0] psel_eff;
	logic [wrf_pkg::cnt_w-1:0] limit;

	wrf_axil u_axil
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.wr(wr),
		.rd_idx(rd_idx),
		.rd_data(rd_data)
	);

	// safety level and effective enable
	assign level2 = st_r.fuse_sync[1];
	assign en_eff = st_r.wd_en || level2 || st_r.rc[wrf_pkg::rc_wd_bit];
	assign running = en_eff || st_r.int_en;
	assign win_open = (st_r.win_cnt != '0);
	// chip reset from any non power-on source
	assign chip_rst = st_r.sys_rst || st_r.ext_sync[1] ||
		st_r.bod_sync[1];

	// divider enable standing in for the slow oscillator
	assign osc_tick =
		(st_r.div_cnt == wrf_pkg::div_w'(osc_div - 1));

	// reserved codes use the longest valid setting
	assign psel_eff = (st_r.psel > wrf_pkg::psel_max) ?
		wrf_pkg::psel_max : st_r.psel;
	assign limit = wrf_pkg::timeout_base << psel_eff;

	assign timeout = running && osc_tick &&
		(st_r.wd_cnt == limit - 1'b1);

	// interrupt request
	assign watchdog_irq = global_irq_enable && st_r.int_en &&
		st_r.int_flag;
	assign watchdog_system_reset = st_r.sys_rst;

	// register read mux
	always_comb
	begin
		rd_data = 8'h00;
		case (rd_idx)
			wrf_pkg::reset_cause_idx:
			begin
				rd_data = {4'h0, st_r.rc};
			end
			wrf_pkg::ctrl_idx:
			begin
				rd_data[wrf_pkg::ct_flag_bit] = st_r.int_flag;
				rd_data[wrf_pkg::ct_ien_bit] = st_r.int_en;
				rd_data[wrf_pkg::ct_psel3_bit] = st_r.psel[3];
				rd_data[wrf_pkg::ct_en_bit] = en_eff;
				rd_data[2:0] = st_r.psel[2:0];
			end
			default:
			begin
				rd_data = 8'h00;
			end
		endcase
	end

	// next state
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.sys_rst = 1'b0;

		// pin synchronisers
		st_nxt.ext_sync = {st_r.ext_sync[0], external_reset_req};
		st_nxt.bod_sync = {st_r.bod_sync[0], brownout_reset_req};
		st_nxt.fuse_sync = {st_r.fuse_sync[0],
			watchdog_always_on_fuse};

		// oscillator divider
		if (osc_tick)
			st_nxt.div_cnt = '0;
		else
			st_nxt.div_cnt = st_r.div_cnt + 1'b1;

		// change window countdown
		if (win_open)
			st_nxt.win_cnt = st_r.win_cnt - 1'b1;

		// watchdog count
		if (!running || watchdog_restart)
			st_nxt.wd_cnt = '0;
		else if (timeout)
			st_nxt.wd_cnt = '0;
		else if (osc_tick)
			st_nxt.wd_cnt = st_r.wd_cnt + 1'b1;

		// software writes
		if (wr.en)
		begin
			case (wr.idx)
				wrf_pkg::protect_idx:
				begin
					if (wr.data == wrf_pkg::protect_signature)
						st_nxt.win_cnt = wrf_pkg::win_w'(
							wrf_pkg::protect_window_cycles);
				end
				wrf_pkg::reset_cause_idx:
				begin
					st_nxt.rc = st_r.rc & wr.data[3:0];
				end
				wrf_pkg::ctrl_idx:
				begin
					if (wr.data[wrf_pkg::ct_flag_bit])
						st_nxt.int_flag = 1'b0;
					st_nxt.int_en = wr.data[wrf_pkg::ct_ien_bit];
					if (wr.data[wrf_pkg::ct_en_bit])
						st_nxt.wd_en = 1'b1;
					else if (win_open && !level2)
						st_nxt.wd_en = 1'b0;
					if (win_open)
					begin
						st_nxt.psel = {wr.data[wrf_pkg::ct_psel3_bit],
							wr.data[2:0]};
						st_nxt.win_cnt = '0;
					end
					if (!running)
						st_nxt.wd_cnt = '0;
				end
				default:
				begin
					st_nxt.win_cnt = st_nxt.win_cnt;
				end
			endcase
		end

		// vector taken clears the flag
		if (watchdog_vector_taken)
			st_nxt.int_flag = 1'b0;

		// timeout action, set wins over clear
		if (timeout)
		begin
			if (st_r.int_en)
			begin
				st_nxt.int_flag = 1'b1;
				if (en_eff)
					st_nxt.int_en = 1'b0;
			end
			else
			begin
				st_nxt.sys_rst = 1'b1;
			end
		end

		// chip reset: note cause, reinit control
		if (chip_rst)
		begin
			st_nxt.int_flag = 1'b0;
			st_nxt.int_en = 1'b0;
			st_nxt.wd_en = 1'b0;
			st_nxt.psel = 4'h0;
			st_nxt.wd_cnt = '0;
			st_nxt.win_cnt = '0;
			if (st_r.sys_rst)
				st_nxt.rc[wrf_pkg::rc_wd_bit] = 1'b1;
			if (st_r.bod_sync[1])
				st_nxt.rc[wrf_pkg::rc_bo_bit] = 1'b1;
			if (st_r.ext_sync[1])
				st_nxt.rc[wrf_pkg::rc_ext_bit] = 1'b1;
		end
	end

	// state register; power-on leaves only its own flag
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_r <= '0;
			st_r.rc <= wrf_pkg::rc_reset;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end
endmodule
